// >>> rtl/npp_host.sv
// Host controller for a high-voltage parallel programming port: turns
// single user requests into timed pin sequences on the device pins.
// Assumes the device pins sit outside mclk's domain; the caller orders
// requests into full programming sequences.
//
// Functional notes
// - Data high byte loads with byte_select_a high, action 01, on load_strobe.
// - Page latch pulse with byte_select_a high copies data into page buffer.
// - Address high byte loads with action 00 and byte_select_a high.
// - Write pulse with byte_select_a low programs flash page; wait for ready.
// - Command 00 with action 10 ends page programming.
// - EEPROM page load: command 11, address high, then address/data/latch repeats.
// - Write pulse programs EEPROM page; next page waits for ready.
// - Fuse write: command 40, data, byte selects a=1 b=0, pulse, then a low.
// - Signature read: command 08, low address, output enable low, select a low.
// - Calibration read: output enable low with byte_select_a high.
// - Action 10 command, 00 address, 01 data, each on load_strobe.
// - Address low byte loads with action 00 and byte_select_a low.
`timescale 1ns/1ps
module npp_host
	import npp_pkg::*;
#(
	parameter int unsigned BUSY_MAX_CYC = CYC_WLRH_MAX,
	parameter int unsigned BUSY_CE_MAX_CYC = CYC_WLRH_CE_MAX
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reqValid,
	output logic reqReady,
	input wire npp_req_t req,
	output logic doneValid,
	output logic timeoutErr,
	output logic [7:0] rdData,
	output npp_pins_t pins,
	output logic [7:0] dataOut,
	output logic dataOe,
	input wire logic [7:0] dataIn,
	input wire logic readyBusy
);

	localparam int WAIT_MIN = CYC_WLRL + SYNC_STAGES;

	typedef struct packed {
		npp_state_t st;
		npp_op_t op;
		logic [20:0] cnt;
		npp_pins_t pins;
		logic [7:0] dataOut;
		logic dataOe;
		logic [7:0] rdData;
		logic eraseCmd;
		logic done;
		logic err;
	} npp_host_t;

	npp_host_t st_r;
	npp_host_t st_nxt;
	logic [8:0] syncOut;
	logic readySync;
	logic [7:0] dataSync;
	logic [20:0] busyLimit;

	npp_pin_sync u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.pinIn({readyBusy, dataIn}),
		.pinOut(syncOut)
	);

	assign readySync = syncOut[8];
	assign dataSync = syncOut[7:0];

	// Erase runs twice as long, so the timeout follows the last command
	assign busyLimit = st_r.eraseCmd ? 21'(BUSY_CE_MAX_CYC + SYNC_STAGES)
		: 21'(BUSY_MAX_CYC + SYNC_STAGES);

	// Sequencer: one request at a time, each pin phase timed by cnt
	always_comb begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		st_nxt.err = 1'b0;
		st_nxt.cnt = st_r.cnt + 21'h1;
		case (st_r.st)
			S_IDLE: begin
				st_nxt.cnt = '0;
				if (reqValid) begin
					st_nxt.op = req.op;
					st_nxt.dataOut = req.data; // Fuse bits pass as given
					st_nxt.dataOe = 1'b1;
					st_nxt.st = S_SETUP;
					case (req.op)
						OP_LOAD_CMD: begin
							{st_nxt.pins.actionSelectHi, st_nxt.pins.actionSelectLo} = AS_CMD;
							st_nxt.pins.byteSelectA = 1'b0;
							st_nxt.eraseCmd = (req.data == CMD_CHIP_ERASE);
						end
						OP_LOAD_ADDR_LO: begin
							{st_nxt.pins.actionSelectHi, st_nxt.pins.actionSelectLo} = AS_ADDR;
							st_nxt.pins.byteSelectA = 1'b0;
						end
						OP_LOAD_ADDR_HI: begin
							{st_nxt.pins.actionSelectHi, st_nxt.pins.actionSelectLo} = AS_ADDR;
							st_nxt.pins.byteSelectA = 1'b1;
						end
						OP_LOAD_DATA_LO: begin
							{st_nxt.pins.actionSelectHi, st_nxt.pins.actionSelectLo} = AS_DATA;
							st_nxt.pins.byteSelectA = 1'b0;
						end
						OP_LOAD_DATA_HI: begin
							{st_nxt.pins.actionSelectHi, st_nxt.pins.actionSelectLo} = AS_DATA;
							st_nxt.pins.byteSelectA = 1'b1;
						end
						OP_PAGE_LATCH: begin
							st_nxt.dataOe = 1'b0;
							st_nxt.pins.byteSelectA = 1'b1;
						end
						OP_WRITE: begin
							st_nxt.dataOe = 1'b0;
							st_nxt.pins.byteSelectA = req.selA;
							st_nxt.pins.byteSelectB = req.selB;
							st_nxt.st = S_WR_SETUP;
						end
						default: begin
							st_nxt.dataOe = 1'b0;
							st_nxt.pins.byteSelectA = req.selA;
							st_nxt.pins.outputEnable_n = 1'b0;
							st_nxt.st = S_RD_WAIT;
						end
					endcase
				end
			end
			S_SETUP: begin
				if (st_r.cnt >= 21'(CYC_DVXH - 1)) begin
					st_nxt.cnt = '0;
					st_nxt.st = S_STROBE;
					if (st_r.op == OP_PAGE_LATCH) begin
						st_nxt.pins.pageLatchStrobe = 1'b1;
					end else begin
						st_nxt.pins.loadStrobe = 1'b1;
					end
				end
			end
			S_STROBE: begin
				if (st_r.cnt >= 21'(CYC_PULSE - 1)) begin
					st_nxt.cnt = '0;
					st_nxt.pins.loadStrobe = 1'b0;
					st_nxt.pins.pageLatchStrobe = 1'b0;
					st_nxt.st = S_HOLD;
				end
			end
			S_HOLD: begin
				// Hold covers both data hold and the strobe low time
				if (st_r.cnt >= 21'(CYC_GAP - 1)) begin
					st_nxt.dataOe = 1'b0;
					st_nxt.done = 1'b1;
					st_nxt.st = S_IDLE;
				end
			end
			S_WR_SETUP: begin
				if (st_r.cnt >= 21'(CYC_BVWL - 1)) begin
					st_nxt.cnt = '0;
					st_nxt.pins.writeStrobe_n = 1'b0;
					st_nxt.st = S_WR_LOW;
				end
			end
			S_WR_LOW: begin
				// cnt keeps running from the falling edge of the write strobe
				if (st_r.cnt >= 21'(CYC_WLWH - 1)) begin
					st_nxt.pins.writeStrobe_n = 1'b1;
					st_nxt.st = S_WAIT_RDY;
				end
			end
			S_WAIT_RDY: begin
				// Busy may take 1 us to appear, so ready is ignored until then
				if (st_r.cnt >= 21'(WAIT_MIN) && readySync) begin
					st_nxt.done = 1'b1;
					st_nxt.pins.byteSelectA = 1'b0;
					st_nxt.pins.byteSelectB = 1'b0;
					st_nxt.st = S_IDLE;
				end else if (st_r.cnt >= busyLimit) begin
					st_nxt.done = 1'b1;
					st_nxt.err = 1'b1;
					st_nxt.pins.byteSelectA = 1'b0;
					st_nxt.pins.byteSelectB = 1'b0;
					st_nxt.st = S_IDLE;
				end
			end
			S_RD_WAIT: begin
				if (st_r.cnt >= 21'(CYC_OLDV + SYNC_STAGES - 1)) begin
					st_nxt.cnt = '0;
					st_nxt.rdData = dataSync;
					st_nxt.pins.outputEnable_n = 1'b1;
					st_nxt.st = S_RD_REL;
				end
			end
			S_RD_REL: begin
				// Let the device release the bus before anyone drives it
				if (st_r.cnt >= 21'(CYC_OHDZ - 1)) begin
					st_nxt.done = 1'b1;
					st_nxt.pins.byteSelectA = 1'b0;
					st_nxt.st = S_IDLE;
				end
			end
			default: begin
				st_nxt.st = S_IDLE;
				st_nxt.pins = PINS_IDLE;
				st_nxt.dataOe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{st: S_IDLE, op: OP_LOAD_CMD, cnt: '0, pins: PINS_IDLE, dataOut: 8'h00,
				dataOe: 1'b0, rdData: 8'h00, eraseCmd: 1'b0, done: 1'b0, err: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// New requests only between sequences, never while waiting for ready
	assign reqReady = (st_r.st == S_IDLE);
	assign doneValid = st_r.done;
	assign timeoutErr = st_r.err;
	assign rdData = st_r.rdData;
	assign pins = st_r.pins;
	assign dataOut = st_r.dataOut;
	assign dataOe = st_r.dataOe;

	// Checks on the pin sequences
	property p_dataHiSel;
		@(posedge mclk) disable iff (!rst_n)
		$rose(pins.loadStrobe) && st_r.op == OP_LOAD_DATA_HI
		|-> !pins.actionSelectHi && pins.actionSelectLo && pins.byteSelectA && dataOe;
	endproperty
	a_dataHiSel: assert property (p_dataHiSel)
		else $error("data high load with wrong selects");

	property p_latchSel;
		@(posedge mclk) disable iff (!rst_n)
		$rose(pins.pageLatchStrobe) |-> pins.byteSelectA && $past(pins.byteSelectA, 8);
	endproperty
	a_latchSel: assert property (p_latchSel)
		else $error("page latch without byte select a high");

	property p_addrHiSel;
		@(posedge mclk) disable iff (!rst_n)
		$rose(pins.loadStrobe) && st_r.op == OP_LOAD_ADDR_HI
		|-> !pins.actionSelectHi && !pins.actionSelectLo && pins.byteSelectA;
	endproperty
	a_addrHiSel: assert property (p_addrHiSel)
		else $error("address high load with wrong selects");

	property p_addrLoSel;
		@(posedge mclk) disable iff (!rst_n)
		$rose(pins.loadStrobe) && st_r.op == OP_LOAD_ADDR_LO
		|-> !pins.actionSelectHi && !pins.actionSelectLo && !pins.byteSelectA;
	endproperty
	a_addrLoSel: assert property (p_addrLoSel)
		else $error("address low load with wrong selects");

	property p_cmdSel;
		@(posedge mclk) disable iff (!rst_n)
		$rose(pins.loadStrobe) && st_r.op == OP_LOAD_CMD
		|-> pins.actionSelectHi && !pins.actionSelectLo && !pins.byteSelectA;
	endproperty
	a_cmdSel: assert property (p_cmdSel)
		else $error("command load with wrong selects");

	property p_strobeSetup;
		@(posedge mclk) disable iff (!rst_n)
		$rose(pins.loadStrobe) |-> $stable(dataOut) && $past(dataOe, 8) ##1 pins.loadStrobe[*8];
	endproperty
	a_strobeSetup: assert property (p_strobeSetup)
		else $error("load strobe setup or width too short");

	property p_writePulse;
		@(posedge mclk) disable iff (!rst_n)
		$fell(pins.writeStrobe_n) |-> $stable(pins.byteSelectA) ##1 !pins.writeStrobe_n[*8];
	endproperty
	a_writePulse: assert property (p_writePulse)
		else $error("write strobe pulse too short or selects moving");

	property p_busyQuiet;
		@(posedge mclk) disable iff (!rst_n)
		st_r.st == S_WAIT_RDY |-> !reqReady && pins.writeStrobe_n && !pins.loadStrobe;
	endproperty
	a_busyQuiet: assert property (p_busyQuiet)
		else $error("pin activity while waiting for ready");

	property p_pollDelay;
		@(posedge mclk) disable iff (!rst_n)
		doneValid && st_r.op == OP_WRITE |-> $past(st_r.cnt) >= 21'(WAIT_MIN);
	endproperty
	a_pollDelay: assert property (p_pollDelay)
		else $error("write finished before busy could appear");

	property p_timeout;
		@(posedge mclk) disable iff (!rst_n)
		st_r.st == S_WAIT_RDY && !readySync && st_r.cnt >= busyLimit |=> timeoutErr && doneValid;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("busy timeout not reported");

	property p_readNoDrive;
		@(posedge mclk) disable iff (!rst_n)
		!pins.outputEnable_n |-> !dataOe;
	endproperty
	a_readNoDrive: assert property (p_readNoDrive)
		else $error("host drives data while device output enabled");

	property p_fuseRelease;
		@(posedge mclk) disable iff (!rst_n)
		doneValid && st_r.op == OP_WRITE |-> !pins.byteSelectA && !pins.byteSelectB;
	endproperty
	a_fuseRelease: assert property (p_fuseRelease)
		else $error("byte select a not returned low after write");

endmodule

// >>> rtl/npp_pkg.sv
// Shared definitions for the parallel programming port controller:
// pin encodings, command codes, request and pin carriers, timing counts.
// Assumes a single 125 MHz clock (8 ns period) drives all logic.
package npp_pkg;

	// Clock period in ns
	localparam int CLK_NS = 8;

	// Action select encodings (hi, lo)
	localparam logic [1:0] AS_ADDR = 2'h0;
	localparam logic [1:0] AS_DATA = 2'h1;
	localparam logic [1:0] AS_CMD = 2'h2;

	// Command codes loaded with AS_CMD
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_READ_SIG = 8'h08;
	localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
	localparam logic [7:0] CMD_WRITE_EEPROM = 8'h11;
	localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;

	// Pin timing figures as printed, in their own units
	localparam int T_DVXH_NS = 67;
	localparam int T_XHXL_NS = 150;
	localparam int T_XLXH_NS = 200;
	localparam int T_BVWL_NS = 67;
	localparam int T_WLWH_NS = 150;
	localparam int T_OLDV_NS = 250;
	localparam int T_OHDZ_NS = 250;
	localparam int T_WLRL_MAX_US = 1;
	localparam int T_WLRH_MAX_US = 4500;
	localparam int T_WLRH_CE_MAX_US = 9000;

	// Least times round up, longest times round down
	localparam int CYC_DVXH = (T_DVXH_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_PULSE = (T_XHXL_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_GAP = (T_XLXH_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_BVWL = (T_BVWL_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_WLWH = (T_WLWH_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_OLDV = (T_OLDV_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_OHDZ = (T_OHDZ_NS + CLK_NS - 1) / CLK_NS;
	localparam int CYC_WLRL = (T_WLRL_MAX_US * 1000) / CLK_NS;
	localparam int CYC_WLRH_MAX = (T_WLRH_MAX_US * 1000) / CLK_NS;
	localparam int CYC_WLRH_CE_MAX = (T_WLRH_CE_MAX_US * 1000) / CLK_NS;

	// Latency of the pin input synchroniser
	localparam int SYNC_STAGES = 2;

	// Operations offered on the user request port
	typedef enum logic [2:0] {
		OP_LOAD_CMD,
		OP_LOAD_ADDR_LO,
		OP_LOAD_ADDR_HI,
		OP_LOAD_DATA_LO,
		OP_LOAD_DATA_HI,
		OP_PAGE_LATCH,
		OP_WRITE,
		OP_READ
	} npp_op_t;

	typedef struct packed {
		npp_op_t op;
		logic selA;
		logic selB;
		logic [7:0] data;
	} npp_req_t;

	// Control pins driven toward the device
	typedef struct packed {
		logic actionSelectHi;
		logic actionSelectLo;
		logic byteSelectA;
		logic byteSelectB;
		logic pageLatchStrobe;
		logic loadStrobe;
		logic writeStrobe_n;
		logic outputEnable_n;
	} npp_pins_t;

	localparam npp_pins_t PINS_IDLE = 8'h03;

	typedef enum logic [3:0] {
		S_IDLE,
		S_SETUP,
		S_STROBE,
		S_HOLD,
		S_WR_SETUP,
		S_WR_LOW,
		S_WAIT_RDY,
		S_RD_WAIT,
		S_RD_REL
	} npp_state_t;

endpackage

// >>> rtl/npp_pin_sync.sv
// Two-stage synchroniser for the data bus and ready_busy pin inputs.
// Assumes the inputs are asynchronous to mclk; only stage two is read.
`timescale 1ns/1ps
module npp_pin_sync
	import npp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [8:0] pinIn,
	output logic [8:0] pinOut
);

	typedef struct packed {
		logic [8:0] stage1;
		logic [8:0] stage2;
	} npp_sync_t;

	npp_sync_t sync_r;
	npp_sync_t sync_nxt;

	// Shift through both stages every edge
	always_comb begin
		sync_nxt = sync_r;
		sync_nxt.stage1 = pinIn;
		sync_nxt.stage2 = sync_r.stage1;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync_r <= '0;
		end else begin
			sync_r <= sync_nxt;
		end
	end

	assign pinOut = sync_r.stage2;

endmodule

// >>> verification/npp_dev_model.sv
// Behavioural model of the programmed device behind the parallel pins.
// Assumes the host drives registered pins on mclk; busy times are scaled down.
`timescale 1ns/1ps
module npp_dev_model
	import npp_pkg::*;
#(
	parameter int BUSY_CYC = 200,
	parameter int ERASE_CYC = 400,
	parameter int WORD_BITS = 5,
	parameter logic [23:0] SIG = 24'h5A3C96, // Arbitrary signature bytes
	parameter logic [7:0] CAL = 8'hA7
)
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire npp_pins_t pins,
	input wire logic [7:0] dataOut,
	input wire logic dataOe,
	input wire logic stuckBusy,
	output logic [7:0] dataIn,
	output logic readyBusy
);
	npp_pins_t prevPins;
	logic [7:0] cmd, addrLo, addrHi, dataLo, dataHi, fuseByte, lastBus, rdByte;
	logic [15:0] flashBuf [256];
	logic [7:0] eepBuf [256];
	logic [15:0] lastPage;
	logic devDrive, writeOk;
	int busyCnt;

	// Bus level; an undriven bus toggles so a stale byte never reads as valid
	assign devDrive = !pins.outputEnable_n && cmd == CMD_READ_SIG;
	assign rdByte = pins.byteSelectA ? CAL : SIG[8*addrLo[1:0] +: 8];
	assign dataIn = dataOe ? dataOut : (devDrive ? rdByte : ~lastBus);
	assign readyBusy = busyCnt == 0 && !stuckBusy;
	// Fuse writes want selects a=1 b=0, page writes want select a low
	assign writeOk = (cmd == CMD_WRITE_FUSE) ? (pins.byteSelectA && !pins.byteSelectB)
		: !pins.byteSelectA;

	// Strobe edges load latches, commit pages and start busy time
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prevPins <= PINS_IDLE;
			{cmd, addrLo, addrHi, dataLo, dataHi, fuseByte, lastBus} <= '0;
			lastPage <= '0;
			busyCnt <= 0;
		end else begin
			prevPins <= pins;
			lastBus <= dataIn;
			if (busyCnt != 0)
				busyCnt <= busyCnt - 1;
			if (pins.loadStrobe && !prevPins.loadStrobe) begin
				case ({pins.actionSelectHi, pins.actionSelectLo})
					AS_CMD: if (busyCnt == 0) cmd <= dataOut;
					AS_ADDR: begin
						if (pins.byteSelectA)
							addrHi <= dataOut;
						else
							addrLo <= dataOut;
					end
					AS_DATA: begin
						if (pins.byteSelectA)
							dataHi <= dataOut;
						else
							dataLo <= dataOut;
					end
					default: ;
				endcase
			end
			if (pins.pageLatchStrobe && !prevPins.pageLatchStrobe && pins.byteSelectA) begin
				if (cmd == CMD_WRITE_FLASH)
					flashBuf[addrLo] <= {dataHi, dataLo};
				if (cmd == CMD_WRITE_EEPROM)
					eepBuf[addrLo] <= dataLo;
			end
			// A write strobe while busy is dropped so the running job finishes
			if (!pins.writeStrobe_n && prevPins.writeStrobe_n && busyCnt == 0 && writeOk) begin
				busyCnt <= (cmd == CMD_CHIP_ERASE) ? ERASE_CYC : BUSY_CYC;
				lastPage <= {addrHi, addrLo} >> WORD_BITS;
				if (cmd == CMD_WRITE_FUSE)
					fuseByte <= dataLo;
			end
		end
	end
endmodule

// >>> verification/test_parallel_nvm_programming_port.sv
// Self-checking bench for the programming port host against a device model.
// Assumes the model answers with scaled busy times and shares mclk.
`timescale 1ns/1ps
module test_parallel_nvm_programming_port
	import npp_pkg::*;
;
	localparam int BUSY_CYC = 200;
	localparam int ERASE_CYC = 400;
	localparam int WORD_BITS = 5;
	localparam logic [23:0] SIG = 24'h5A3C96; // Arbitrary signature bytes
	localparam logic [7:0] CAL = 8'hA7;

	logic mclk, rst_n, reqValid, reqReady, doneValid, timeoutErr, dataOe, readyBusy, stuckBusy;
	logic gotTo;
	logic [7:0] rdData, dataOut, dataIn, gotRd;
	npp_req_t req;
	npp_pins_t pins;
	int n_errors, tests_run, elapsed;

	// Host timeouts sit above the model's busy times so good writes finish
	npp_host #(.BUSY_MAX_CYC(300), .BUSY_CE_MAX_CYC(600)) dut_u (.mclk(mclk), .rst_n(rst_n),
		.reqValid(reqValid), .reqReady(reqReady), .req(req), .doneValid(doneValid),
		.timeoutErr(timeoutErr), .rdData(rdData), .pins(pins), .dataOut(dataOut),
		.dataOe(dataOe), .dataIn(dataIn), .readyBusy(readyBusy));
	npp_dev_model #(.BUSY_CYC(BUSY_CYC), .ERASE_CYC(ERASE_CYC), .WORD_BITS(WORD_BITS),
		.SIG(SIG), .CAL(CAL)) dev_u (.mclk(mclk), .rst_n(rst_n), .pins(pins),
		.dataOut(dataOut), .dataOe(dataOe), .stuckBusy(stuckBusy), .dataIn(dataIn),
		.readyBusy(readyBusy));

	// Verdict and end of run
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One request: wait for ready, hold valid over the take edge, wait for done
	task automatic do_req(input npp_op_t op, input logic a, input logic b, input logic [7:0] d);
		int i;
		i = 0;
		while (reqReady !== 1'b1 && i < 100) begin
			@(posedge mclk);
			#1;
			i++;
		end
		// A host that never comes back to idle is a failure, not a hang
		if (reqReady !== 1'b1) begin
			n_errors++;
			$display("mismatch reqReady expected 1 seen %b", reqReady);
			end_of_test();
		end
		req = '{op: op, selA: a, selB: b, data: d};
		reqValid = 1'b1;
		@(posedge mclk);
		#1;
		reqValid = 1'b0;
		for (elapsed = 1; doneValid !== 1'b1; elapsed++) begin
			if (elapsed > 2000) begin
				n_errors++;
				$display("mismatch doneValid expected 1 seen none");
				end_of_test();
			end
			@(posedge mclk);
			#1;
		end
		gotTo = timeoutErr;
		gotRd = rdData;
	endtask

	task automatic t_flash();
		do_req(OP_LOAD_CMD, 1'b0, 1'b0, CMD_WRITE_FLASH);
		do_req(OP_LOAD_ADDR_LO, 1'b0, 1'b0, 8'hA5);
		do_req(OP_LOAD_DATA_LO, 1'b0, 1'b0, 8'h3C);
		do_req(OP_LOAD_DATA_HI, 1'b1, 1'b0, 8'hC3);
		do_req(OP_PAGE_LATCH, 1'b1, 1'b0, 8'h00);
		chk("flash word", 16'hC33C, dev_u.flashBuf[8'hA5]);
		do_req(OP_LOAD_ADDR_HI, 1'b1, 1'b0, 8'h01);
		do_req(OP_WRITE, 1'b0, 1'b0, 8'h00);
		chk("flash timeout", 16'h0000, gotTo);
		chk("flash busy span", 16'h0001, elapsed >= BUSY_CYC && elapsed < ERASE_CYC);
		chk("flash page", 16'h01A5 >> WORD_BITS, dev_u.lastPage);
		do_req(OP_LOAD_CMD, 1'b0, 1'b0, CMD_NOP);
		chk("end command", CMD_NOP, dev_u.cmd);
		$display("test flash page done");
	endtask

	// Two bytes into the page buffer, then one commit
	task automatic t_eeprom();
		do_req(OP_LOAD_CMD, 1'b0, 1'b0, CMD_WRITE_EEPROM);
		do_req(OP_LOAD_ADDR_HI, 1'b1, 1'b0, 8'h00);
		for (int i = 0; i < 2; i++) begin
			do_req(OP_LOAD_ADDR_LO, 1'b0, 1'b0, 8'h10 + 8'(i));
			do_req(OP_LOAD_DATA_LO, 1'b0, 1'b0, 8'h50 + 8'(i));
			do_req(OP_PAGE_LATCH, 1'b1, 1'b0, 8'h00);
		end
		chk("eeprom byte 0", 16'h0050, dev_u.eepBuf[8'h10]);
		chk("eeprom byte 1", 16'h0051, dev_u.eepBuf[8'h11]);
		do_req(OP_WRITE, 1'b0, 1'b0, 8'h00);
		chk("eeprom timeout", 16'h0000, gotTo);
		$display("test eeprom page done");
	endtask

	task automatic t_fuse();
		do_req(OP_LOAD_CMD, 1'b0, 1'b0, CMD_WRITE_FUSE);
		do_req(OP_LOAD_DATA_LO, 1'b0, 1'b0, 8'hE1);
		do_req(OP_WRITE, 1'b1, 1'b0, 8'h00);
		chk("fuse timeout", 16'h0000, gotTo);
		chk("fuse byte", 16'h00E1, dev_u.fuseByte);
		@(posedge mclk);
		#1;
		chk("select a after fuse", 16'h0000, pins.byteSelectA);
		$display("test fuse write done");
	endtask

	// Every signature address, then the calibration byte
	task automatic t_read();
		do_req(OP_LOAD_CMD, 1'b0, 1'b0, CMD_READ_SIG);
		for (int i = 0; i < 3; i++) begin
			do_req(OP_LOAD_ADDR_LO, 1'b0, 1'b0, 8'(i));
			do_req(OP_READ, 1'b0, 1'b0, 8'h00);
			chk("signature byte", {8'h00, SIG[8*i +: 8]}, gotRd);
		end
		do_req(OP_LOAD_ADDR_LO, 1'b0, 1'b0, 8'h00);
		do_req(OP_READ, 1'b1, 1'b0, 8'h00);
		chk("calibration byte", {8'h00, CAL}, gotRd);
		chk("output enable off", 16'h0001, pins.outputEnable_n);
		$display("test reads done");
	endtask

	task automatic t_erase();
		do_req(OP_LOAD_CMD, 1'b0, 1'b0, CMD_CHIP_ERASE);
		do_req(OP_WRITE, 1'b0, 1'b0, 8'h00);
		chk("erase timeout", 16'h0000, gotTo);
		chk("erase busy span", 16'h0001, elapsed >= ERASE_CYC);
		$display("test chip erase done");
	endtask

	// A device that never returns ready must end in a reported timeout
	task automatic t_stuck();
		stuckBusy = 1'b1;
		do_req(OP_LOAD_CMD, 1'b0, 1'b0, CMD_WRITE_FLASH);
		do_req(OP_WRITE, 1'b0, 1'b0, 8'h00);
		chk("stuck timeout", 16'h0001, gotTo);
		chk("stuck span", 16'h0001, elapsed < ERASE_CYC);
		stuckBusy = 1'b0;
		$display("test stuck busy done");
	endtask

	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		reqValid = 1'b0;
		req = '0;
		stuckBusy = 1'b0;
		n_errors = 0;
		tests_run = 0;
		repeat (2) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		chk("reset ready", 16'h0001, reqReady);
		chk("reset pins", {8'h00, PINS_IDLE}, pins);
		t_flash();
		t_eeprom();
		t_fuse();
		t_read();
		t_erase();
		t_stuck();
		end_of_test();
	end
endmodule
